// File: logic/dram_ctrl_pkg.sv
// Package for the fast page memory module controller.
// Assumes a 40 MHz ref_clk; all timing counts derive from it.
package dram_ctrl_pkg;
   localparam int CLK_PERIOD_PS = 25000;
   // Timing figures in their printed units
   localparam int ROW_PRECHARGE_NS = 80;
   localparam int ROW_PULSE_NS = 100;
   localparam int ROW_TO_COL_NS = 15;
   localparam int COL_PULSE_NS = 25;
   localparam int COLUMN_PRECHARGE_MIN_NS = 15;
   localparam int ROW_TO_WRITE_DELAY_NS = 90;
   localparam int COLUMN_ADDRESS_TO_WRITE_DELAY_NS = 50;
   localparam int COLUMN_STROBE_TO_WRITE_DELAY_NS = 35;
   localparam int WAKE_PAUSE_US = 100;
   localparam int REFRESH_PERIOD_MS = 8;
   localparam int WAKE_CYCLES = 8;
   localparam int REFRESH_ROWS = 512;
   // Least times rounded up to whole cycles
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc
   localparam int T_RP_CYC = ns_to_cyc(ROW_PRECHARGE_NS);
   localparam int T_RAS_CYC = ns_to_cyc(ROW_PULSE_NS);
   localparam int T_RCD_CYC = ns_to_cyc(ROW_TO_COL_NS);
   localparam int T_CAS_CYC = ns_to_cyc(COL_PULSE_NS);
   localparam int T_CPN_CYC = ns_to_cyc(COLUMN_PRECHARGE_MIN_NS);
   localparam int T_RWD_CYC = ns_to_cyc(ROW_TO_WRITE_DELAY_NS);
   localparam int T_AWD_CYC = ns_to_cyc(COLUMN_ADDRESS_TO_WRITE_DELAY_NS);
   localparam int T_CWD_CYC = ns_to_cyc(COLUMN_STROBE_TO_WRITE_DELAY_NS);
   localparam int WAKE_PAUSE_CYC = (WAKE_PAUSE_US * 1000000) / CLK_PERIOD_PS;
   // Rows spread over the deadline, rounded down; the pacing counter then waits one cycle more per row
   localparam int REFRESH_INTERVAL_CYC =
      int'((64'(REFRESH_PERIOD_MS) * 64'd1000000000) / CLK_PERIOD_PS / REFRESH_ROWS);
   localparam int ROW_BITS = 10;
   localparam int REFRESH_ADDR_BITS = 9;
   localparam int DATA_LANES = 8;
   localparam int CNT_W = 16;
   localparam logic [3:0] WAKE_CNT_RESET = 4'h0;
   typedef enum {
      ST_PAUSE, ST_WAKE_LOW, ST_WAKE_HIGH, ST_IDLE, ST_ROW, ST_COL, ST_COL_END,
      ST_LATE_WRITE, ST_CBR_SETUP, ST_CBR_ROW, ST_HIDDEN_HIGH, ST_HIDDEN_LOW,
      ST_PRECHARGE
   } ctrl_state_t;
endpackage : dram_ctrl_pkg

// File: logic/dram_ctrl.sv
// Host controller that drives a one-megabit-deep, nine-lane fast page memory module.
// Assumes strobes, address and data pins reach the module directly; module outputs
// are asynchronous and are brought in through two flip-flops.
// Operation
// - Row half then column half, ten lines
// - Write strobe high reads, low writes
// - Both strobes high end the cycle
// - All 512 rows refreshed every 8ms; the code spaces refreshes 626 cycles apart, about 8.013ms for all 512 rows
// - Page mode reads, writes, read-modify-writes
// - Row once, toggle columns, row high ends
// - Hidden refresh after read keeps column low
// - Wait 100us, eight row cycles, repeat
// - Pulse column high to clear output
`timescale 1ns/10ps
module dram_ctrl
   import dram_ctrl_pkg::*;
#(
   parameter int WAKE_PAUSE = WAKE_PAUSE_CYC,
   parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   // User request port
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_rmw,
   input wire logic req_page_last,
   input wire logic req_hidden,
   input wire logic [2*ROW_BITS-1:0] req_addr,
   input wire logic [DATA_LANES:0] req_wdata,
   output logic rsp_valid,
   output logic [DATA_LANES:0] rsp_rdata,
   output logic init_done,
   // Module pins
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic ninth_lane_column_strobe_n,
   output logic write_strobe_n,
   output logic [ROW_BITS-1:0] mux_address_lines,
   input wire logic [DATA_LANES-1:0] shared_data_lanes_in,
   output logic [DATA_LANES-1:0] shared_data_lanes_out,
   output logic shared_data_lanes_oe,
   output logic ninth_lane_data_input,
   input wire logic ninth_lane_data_output,
   input wire logic module_presence_pin
);
   typedef struct packed {
      ctrl_state_t st;
      logic [CNT_W-1:0] tmr;
      logic [CNT_W-1:0] ref_tmr;
      logic ref_due;
      logic missed;
      logic [3:0] wake_cnt;
      logic in_page;
      logic hidden;
      logic wr;
      logic rmw;
      logic last;
      logic [2*ROW_BITS-1:0] addr;
      logic [DATA_LANES:0] wdata;
      logic ras_n, cas_n, we_n, oe;
      logic [ROW_BITS-1:0] a;
      logic [DATA_LANES:0] dout;
      logic rsp_v;
      logic [DATA_LANES:0] rdata;
      logic [DATA_LANES:0] sync1, sync2;
      logic pres1, pres2;
      logic init;
   } state_t;
   state_t s_reg, s_next;
   wire logic take = req_valid && req_ready;
   localparam logic [CNT_W-1:0] ONE = 16'h0001;

   // Cycle count converted to the counter width
   function automatic logic [CNT_W-1:0] cyc(input int n);
      return CNT_W'(n);
   endfunction : cyc

   // Ready in idle, or at column end while a page is open, only with the module present; never with refresh due
   assign req_ready = s_reg.init && s_reg.pres2 && !s_reg.ref_due
      && (s_reg.st == ST_IDLE
      || (s_reg.st == ST_COL_END && s_reg.tmr == '0 && !s_reg.last));
   always_comb begin
      s_next = s_reg;
      s_next.rsp_v = 1'b0;
      // Input pins pass two flops before use
      s_next.sync1 = {ninth_lane_data_output, shared_data_lanes_in};
      s_next.sync2 = s_reg.sync1;
      s_next.pres1 = module_presence_pin;
      s_next.pres2 = s_reg.pres1;
      if (s_reg.tmr != '0) s_next.tmr = s_reg.tmr - ONE;
      // Refresh pacing; a missed deadline forces another wake-up
      if (s_reg.ref_tmr != '0) begin
         s_next.ref_tmr = s_reg.ref_tmr - ONE;
      end else begin
         s_next.ref_tmr = cyc(REFRESH_INTERVAL);
         if (s_reg.ref_due && s_reg.init) s_next.missed = 1'b1;
         s_next.ref_due = 1'b1;
      end
      case (s_reg.st)
         ST_PAUSE: begin
            s_next.ras_n = 1'b1;
            s_next.cas_n = 1'b1;
            if (s_reg.tmr == '0) begin
               s_next.st = ST_WAKE_LOW;
               s_next.ras_n = 1'b0;
               s_next.tmr = cyc(T_RAS_CYC);
            end
         end
         ST_WAKE_LOW: if (s_reg.tmr == '0) begin
            s_next.ras_n = 1'b1;
            s_next.tmr = cyc(T_RP_CYC);
            s_next.wake_cnt = s_reg.wake_cnt + 4'h1;
            s_next.st = ST_WAKE_HIGH;
         end
         ST_WAKE_HIGH: if (s_reg.tmr == '0) begin
            if (s_reg.wake_cnt == 4'(WAKE_CYCLES)) begin
               s_next.init = 1'b1;
               s_next.missed = 1'b0;
               s_next.st = ST_IDLE;
            end else begin
               s_next.ras_n = 1'b0;
               s_next.tmr = cyc(T_RAS_CYC);
               s_next.st = ST_WAKE_LOW;
            end
         end
         ST_IDLE: begin
            s_next.oe = 1'b0;
            if (s_reg.missed) begin
               s_next.init = 1'b0;
               s_next.wake_cnt = WAKE_CNT_RESET;
               s_next.ras_n = 1'b0;
               s_next.tmr = cyc(T_RAS_CYC);
               s_next.st = ST_WAKE_LOW;
            end else if (s_reg.ref_due && s_reg.init) begin
               // Column low first so the device uses its own counter
               s_next.cas_n = 1'b0;
               s_next.tmr = ONE;
               s_next.ref_due = 1'b0;
               s_next.st = ST_CBR_SETUP;
            end else if (take) begin
               s_next.addr = req_addr;
               s_next.wdata = req_wdata;
               s_next.wr = req_write;
               s_next.rmw = req_rmw;
               s_next.last = req_page_last;
               s_next.hidden = req_hidden && !req_write && !req_rmw;
               s_next.a = req_addr[2*ROW_BITS-1:ROW_BITS];
               s_next.ras_n = 1'b0;
               s_next.tmr = cyc(T_RCD_CYC);
               s_next.st = ST_ROW;
            end
         end
         ST_ROW, ST_COL_END: if (s_reg.tmr == '0 && (s_reg.st == ST_ROW || take
               || s_reg.in_page)) begin
            // Present the column half and drop the column strobe in the same cycle
            if (s_reg.st == ST_COL_END && !s_reg.in_page) begin
               s_next.addr = req_addr;
               s_next.wdata = req_wdata;
               s_next.wr = req_write;
               s_next.rmw = req_rmw;
               s_next.last = req_page_last;
            end
            s_next.in_page = 1'b0;
            s_next.a = (s_reg.st == ST_COL_END && !s_reg.in_page) ?
               req_addr[ROW_BITS-1:0] : s_reg.addr[ROW_BITS-1:0];
            s_next.we_n = !(s_reg.st == ST_COL_END && !s_reg.in_page ? req_write
               : s_reg.wr); // Early write set with the strobe
            s_next.dout = (s_reg.st == ST_COL_END && !s_reg.in_page) ? req_wdata
               : s_reg.wdata;
            s_next.oe = (s_reg.st == ST_COL_END && !s_reg.in_page) ? req_write
               : s_reg.wr;
            s_next.cas_n = 1'b0;
            s_next.tmr = cyc(T_CAS_CYC > T_RWD_CYC - T_RCD_CYC ? T_CAS_CYC + 2
               : T_RWD_CYC - T_RCD_CYC + 2);
            s_next.st = ST_COL;
         end else if (s_reg.st == ST_COL_END && s_reg.tmr == '0
               && (s_reg.last || s_reg.ref_due)) begin
            // A due refresh closes an open page so the refresh counter keeps pace
            s_next.ras_n = 1'b1;
            s_next.tmr = cyc(T_RP_CYC);
            s_next.st = ST_PRECHARGE;
         end
         ST_COL: if (s_reg.tmr == '0) begin
            if (!s_reg.wr) begin
               // Data has crossed both sync flops while column stays low
               s_next.rdata = s_reg.sync2;
               s_next.rsp_v = 1'b1;
            end
            if (s_reg.rmw && s_reg.we_n) begin
               // Write falls after read-write delays met
               s_next.we_n = 1'b0;
               s_next.oe = 1'b1;
               s_next.tmr = cyc(T_CWD_CYC > T_AWD_CYC ? T_CWD_CYC : T_AWD_CYC);
               s_next.st = ST_LATE_WRITE;
            end else if (s_reg.hidden) begin
               s_next.ras_n = 1'b1; // Column held low across refresh
               s_next.tmr = cyc(T_RP_CYC);
               s_next.st = ST_HIDDEN_HIGH;
            end else begin
               s_next.cas_n = 1'b1; // Column high releases the device outputs
               s_next.oe = 1'b0;
               s_next.we_n = 1'b1;
               s_next.tmr = cyc(T_CPN_CYC);
               s_next.in_page = 1'b0;
               s_next.st = ST_COL_END;
            end
         end
         ST_LATE_WRITE: if (s_reg.tmr == '0) begin
            s_next.cas_n = 1'b1;
            s_next.we_n = 1'b1;
            s_next.oe = 1'b0;
            s_next.rmw = 1'b0;
            s_next.tmr = cyc(T_CPN_CYC);
            s_next.st = ST_COL_END;
         end
         ST_HIDDEN_HIGH: if (s_reg.tmr == '0) begin
            s_next.ras_n = 1'b0;
            s_next.tmr = cyc(T_RAS_CYC);
            s_next.st = ST_HIDDEN_LOW;
         end
         ST_HIDDEN_LOW: if (s_reg.tmr == '0) begin
            s_next.ras_n = 1'b1;
            s_next.cas_n = 1'b1;
            s_next.hidden = 1'b0;
            s_next.tmr = cyc(T_RP_CYC);
            s_next.st = ST_PRECHARGE;
         end
         ST_CBR_SETUP: if (s_reg.tmr == '0) begin
            s_next.ras_n = 1'b0;
            s_next.tmr = cyc(T_RAS_CYC);
            s_next.st = ST_CBR_ROW;
         end
         ST_CBR_ROW: if (s_reg.tmr == '0) begin
            s_next.ras_n = 1'b1;
            s_next.cas_n = 1'b1;
            s_next.tmr = cyc(T_RP_CYC);
            s_next.st = ST_PRECHARGE;
         end
         ST_PRECHARGE: if (s_reg.tmr == '0) s_next.st = ST_IDLE;
         default: s_next.st = ST_IDLE;
      endcase
      // Page continues without a row cycle when the burst is open
      if (s_reg.st == ST_COL_END && s_reg.tmr == '0 && !s_reg.last && take)
         s_next.in_page = 1'b0;
   end

   // All state in one register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.st <= ST_PAUSE;
         s_reg.tmr <= cyc(WAKE_PAUSE);
         s_reg.ref_tmr <= cyc(REFRESH_INTERVAL);
         s_reg.ras_n <= 1'b1;
         s_reg.cas_n <= 1'b1;
         s_reg.we_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Ninth lane shares timing with its own strobe pin
   assign row_strobe_n = s_reg.ras_n;
   assign col_strobe_n = s_reg.cas_n;
   assign ninth_lane_column_strobe_n = s_reg.cas_n;
   assign write_strobe_n = s_reg.we_n;
   assign mux_address_lines = s_reg.a;
   assign shared_data_lanes_out = s_reg.dout[DATA_LANES-1:0];
   assign shared_data_lanes_oe = s_reg.oe;
   assign ninth_lane_data_input = s_reg.dout[DATA_LANES];
   assign rsp_valid = s_reg.rsp_v;
   assign rsp_rdata = s_reg.rdata;
   assign init_done = s_reg.init;
endmodule : dram_ctrl

// File: verif/dram_ctrl_checker.sv
// Pin checker for the memory module controller.
// Assumes it is bound into dram_ctrl and sees only its ports.
`timescale 1ns/10ps
module dram_ctrl_checker #(
   parameter int WAKE_PAUSE = 20,
   parameter int REFRESH_INTERVAL = 200
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic req_ready,
   input wire logic init_done,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic ninth_lane_column_strobe_n,
   input wire logic write_strobe_n,
   input wire logic shared_data_lanes_oe
);
   logic row_q;
   logic [3:0] falls;
   logic [15:0] since_rst;
   logic [15:0] since_row;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Row falls, cycles since reset and since the last row cycle
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         row_q <= 1'b1;
         falls <= 4'h0;
         since_rst <= 16'h0;
         since_row <= 16'h0;
      end else begin
         row_q <= row_strobe_n;
         if (row_q && !row_strobe_n && falls != 4'hf) falls <= falls + 4'h1;
         if (since_rst != 16'hffff) since_rst <= since_rst + 16'h1;
         since_row <= (row_q && !row_strobe_n) ? 16'h0 : since_row + 16'h1;
      end
   end
   a_wake_pause: assert property (
      row_q && !row_strobe_n && falls == 4'h0 |-> since_rst >= 16'(WAKE_PAUSE))
      else $error("row strobe before wake pause ended");
   a_wake_count: assert property (
      $rose(init_done) |-> falls >= 4'h8) else $error("ready before eight row cycles");
   a_ready_woken: assert property (
      req_ready |-> init_done) else $error("request taken before wake-up");
   a_refresh_gap: assert property (
      init_done |-> since_row <= 16'(2 * REFRESH_INTERVAL + 64))
      else $error("row cycles too far apart");
   a_row_precharge: assert property (
      $rose(row_strobe_n) |-> row_strobe_n[*4]) else $error("row high time too short");
   a_idle_both_high: assert property (
      req_ready && row_strobe_n |-> col_strobe_n) else $error("idle with column low");
   a_early_write: assert property (
      $fell(col_strobe_n) && !row_strobe_n && !write_strobe_n |-> shared_data_lanes_oe)
      else $error("early write without data driven");
   a_no_contend: assert property (
      !col_strobe_n && write_strobe_n |-> !shared_data_lanes_oe)
      else $error("data driven during read");
   a_page_row_low: assert property (
      $fell(col_strobe_n) && !row_strobe_n |-> !row_strobe_n[*2])
      else $error("row released under column");
   a_cbr_row: assert property (
      $fell(col_strobe_n) && row_strobe_n |-> ##[1:4] !row_strobe_n)
      else $error("column-first refresh without row fall");
   a_ninth_strobe: assert property (
      ninth_lane_column_strobe_n == col_strobe_n) else $error("ninth strobe apart");
endmodule : dram_ctrl_checker
bind dram_ctrl dram_ctrl_checker #(.WAKE_PAUSE(WAKE_PAUSE),
   .REFRESH_INTERVAL(REFRESH_INTERVAL)) chk_u (.ref_clk, .arst_n, .req_ready, .init_done,
   .row_strobe_n, .col_strobe_n, .ninth_lane_column_strobe_n, .write_strobe_n,
   .shared_data_lanes_oe);

// File: verif/dram_module_model.sv
// Behavioural nine-lane memory module answering the controller's strobes.
// Assumes strobes change together on the controller clock; reacts to falls 1 ns later, releases the outputs at once on column high.
`timescale 1ns/10ps
module dram_module_model (
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic ninth_lane_column_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [9:0] mux_address_lines,
   input wire logic [7:0] shared_data_lanes_out,
   input wire logic shared_data_lanes_oe,
   input wire logic ninth_lane_data_input,
   output logic [7:0] shared_data_lanes_in,
   output logic ninth_lane_data_output
);
   logic [8:0] mem [logic [19:0]];
   logic [9:0] row = 10'h0;
   logic [19:0] addr = 20'h0;
   logic [8:0] q = 9'h0;
   logic drive = 1'b0;
   int wake_cnt = 0;
   int cbr_cnt = 0;
   int err_cnt = 0;
   // Row fall: row half, or internal counter when column is already low
   always @(negedge row_strobe_n) begin
      #1;
      wake_cnt++;
      if (!col_strobe_n) cbr_cnt++;
      else row = mux_address_lines;
   end
   // Column fall: early write stores and stays open, read drives the cell
   always @(negedge col_strobe_n) begin
      #1;
      if (!row_strobe_n) begin
         addr = {row, mux_address_lines};
         if (wake_cnt < 8) err_cnt++;
         if (!write_strobe_n) begin
            mem[addr] = {ninth_lane_data_input, shared_data_lanes_oe ? shared_data_lanes_out :
               ~shared_data_lanes_out};
         end else begin
            q = mem.exists(addr) ? mem[addr] : 9'h0;
            drive = 1'b1;
         end
      end
   end
   // Late write: data taken at the write fall, read data keeps driving
   always @(negedge write_strobe_n) begin
      #1;
      if (!col_strobe_n && !row_strobe_n) begin
         mem[addr] = {ninth_lane_data_input, shared_data_lanes_out};
      end
   end
   // Column high opens the outputs; released lines show the inverse
   always @(posedge col_strobe_n) drive = 1'b0;
   assign {ninth_lane_data_output, shared_data_lanes_in} = drive ? q : ~q;
endmodule : dram_module_model

// File: verif/dram_ctrl_test.sv
// Self-checking bench for the memory module controller.
// Assumes the behavioural module model and the bound pin checker.
`timescale 1ns/10ps
module dram_ctrl_test;
   import dram_ctrl_pkg::*;
   localparam int PAUSE = 20;
   localparam int RINT = 200;
   logic ref_clk, arst_n, req_valid, req_ready, req_write, req_rmw, req_page_last, req_hidden;
   logic rsp_valid, init_done, row_strobe_n, col_strobe_n, ninth_lane_column_strobe_n;
   logic write_strobe_n, shared_data_lanes_oe, ninth_lane_data_input, ninth_lane_data_output;
   logic module_presence_pin;
   logic [2*ROW_BITS-1:0] req_addr;
   logic [DATA_LANES:0] req_wdata, rsp_rdata;
   logic [ROW_BITS-1:0] mux_address_lines;
   logic [DATA_LANES-1:0] shared_data_lanes_in, shared_data_lanes_out;
   logic [DATA_LANES:0] exp_q [$];
   logic [DATA_LANES:0] ref_mem [logic [19:0]];
   logic [19:0] adr [6];
   int error_cnt = 0;
   int compares = 0;
   dram_ctrl #(.WAKE_PAUSE(PAUSE), .REFRESH_INTERVAL(RINT)) dut_u (.ref_clk, .arst_n, .req_valid,
      .req_ready, .req_write, .req_rmw, .req_page_last, .req_hidden, .req_addr, .req_wdata,
      .rsp_valid, .rsp_rdata, .init_done, .row_strobe_n, .col_strobe_n,
      .ninth_lane_column_strobe_n, .write_strobe_n, .mux_address_lines, .shared_data_lanes_in,
      .shared_data_lanes_out, .shared_data_lanes_oe, .ninth_lane_data_input,
      .ninth_lane_data_output, .module_presence_pin);
   dram_module_model mdl_u (.row_strobe_n, .col_strobe_n, .ninth_lane_column_strobe_n,
      .write_strobe_n, .mux_address_lines, .shared_data_lanes_out, .shared_data_lanes_oe,
      .ninth_lane_data_input, .shared_data_lanes_in, .ninth_lane_data_output);
   // 40 MHz reference
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk_word(input logic [8:0] exp, input logic [8:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk_word
   task automatic chk_num(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk_num
   task automatic give_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // Offer one request and hold it until taken; a stuck handshake ends the run
   task automatic do_req(input logic w, m, l, h, input logic [19:0] a, input logic [8:0] d);
      int n;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      {req_write, req_rmw, req_page_last, req_hidden, req_addr, req_wdata} <= {w, m, l, h, a, d};
      if (!w) exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : 9'h0);
      if (w || m) ref_mem[a] = d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 3000);
      if (n >= 3000) chk_num(32'h1, 32'h0);
      if (n >= 3000) give_verdict();
      req_valid <= 1'b0;
   endtask : do_req
   // One row, columns 0 and 3ff included, closed on the fourth access
   task automatic page_run(input logic w, input logic m);
      for (int i = 0; i < 4; i++)
         do_req(w, m, i == 3, 1'b0, {10'h155, 10'(i * 341)}, 9'($urandom));
   endtask : page_run
   // Response watcher: each read answer takes the oldest note
   always @(posedge ref_clk) begin
      if (rsp_valid === 1'b1)
         chk_word(exp_q.size() ? exp_q.pop_front() : ~rsp_rdata, rsp_rdata);
   end
   initial begin
      int n;
      int c0;
      {arst_n, req_valid, req_write, req_rmw, req_page_last, req_hidden} = 6'h0;
      {req_addr, req_wdata, module_presence_pin} = 30'h1;
      void'($urandom(92));
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      n = 0;
      while (init_done !== 1'b1 && n < 1000) begin
         @(posedge ref_clk);
         n++;
      end
      chk_num(32'h8, 32'(mdl_u.wake_cnt));
      $display("wake-up test done");
      for (int i = 0; i < 6; i++) begin
         adr[i] = (i == 0) ? 20'h0 : (i == 1) ? 20'hfffff : 20'($urandom);
         do_req(1'b1, 1'b0, 1'b1, 1'b0, adr[i], 9'($urandom));
      end
      for (int i = 5; i >= 0; i--) do_req(1'b0, 1'b0, 1'b1, 1'b0, adr[i], 9'h0);
      $display("single access test done");
      page_run(1'b1, 1'b0);
      page_run(1'b0, 1'b0);
      page_run(1'b0, 1'b1);
      page_run(1'b0, 1'b0);
      $display("page test done");
      c0 = mdl_u.cbr_cnt;
      do_req(1'b0, 1'b0, 1'b1, 1'b1, adr[2], 9'h0);
      // The hidden row fall comes well after the request is taken
      n = 0;
      while (mdl_u.cbr_cnt == c0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk_num(32'h1, 32'(mdl_u.cbr_cnt > c0));
      c0 = mdl_u.cbr_cnt;
      repeat (3 * RINT + 10) @(posedge ref_clk);
      chk_num(32'h1, 32'((mdl_u.cbr_cnt - c0) inside {[3:4]}));
      for (int i = 0; i < 6; i++) do_req(1'b0, 1'b0, 1'b1, 1'b0, adr[i], 9'h0);
      $display("refresh test done");
      module_presence_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk) chk_num(32'h0, 32'(req_ready));
      module_presence_pin <= 1'b1;
      do_req(1'b0, 1'b0, 1'b1, 1'b0, adr[1], 9'h0);
      $display("presence test done");
      n = 0;
      while (exp_q.size() != 0 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk_num(32'h0, 32'(exp_q.size()));
      chk_num(32'h0, 32'(mdl_u.err_cnt));
      give_verdict();
   end
endmodule : dram_ctrl_test
